/* File: asq_pkg.sv */
// package for the converter scan sequencer: register map, field positions, timing counts
// assumes a 25 MHz system clock where one state is one clock cycle
package asq_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte wide registers, byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ASQ_OFS_RES_A_HI = 8'h00;
  localparam logic [7:0] ASQ_OFS_RES_A_LO = 8'h01;
  localparam logic [7:0] ASQ_OFS_RES_B_HI = 8'h02;
  localparam logic [7:0] ASQ_OFS_RES_B_LO = 8'h03;
  localparam logic [7:0] ASQ_OFS_RES_C_HI = 8'h04;
  localparam logic [7:0] ASQ_OFS_RES_C_LO = 8'h05;
  localparam logic [7:0] ASQ_OFS_RES_D_HI = 8'h06;
  localparam logic [7:0] ASQ_OFS_RES_D_LO = 8'h07;
  localparam logic [7:0] ASQ_OFS_CTRL_STAT = 8'h08;
  localparam logic [7:0] ASQ_OFS_TRIG_CTRL = 8'h09;

  // ----------------------------------------------------------------
  // field positions in the control/status and trigger control registers
  // ----------------------------------------------------------------
  localparam int ASQ_BIT_DONE  = 7;
  localparam int ASQ_BIT_IRQEN = 6;
  localparam int ASQ_BIT_GO    = 5;
  localparam int ASQ_BIT_SCAN  = 4;
  localparam int ASQ_BIT_SPEED = 3;
  localparam int ASQ_BIT_GROUP = 2;
  localparam int ASQ_BIT_TRGEN = 7;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ASQ_RST_CTRL_STAT = 8'h00;
  localparam logic [7:0] ASQ_RST_TRIG_CTRL = 8'h7F;
  localparam logic [7:0] ASQ_TRIG_RSVD     = 8'h7F;

  // ----------------------------------------------------------------
  // timing in states (one state = one clock cycle)
  // ----------------------------------------------------------------
  localparam int ASQ_CLK_MHZ        = 25;
  localparam int ASQ_STATE_PER_CLK  = 1;
  localparam int ASQ_SLOW_DELAY_MIN = 10;
  localparam int ASQ_SLOW_DELAY_MAX = 17;
  localparam int ASQ_FAST_DELAY_MIN = 6;
  localparam int ASQ_FAST_DELAY_MAX = 9;
  localparam int ASQ_SLOW_SAMPLE    = 64;
  localparam int ASQ_FAST_SAMPLE    = 32;
  localparam int ASQ_SLOW_CONV      = 256;
  localparam int ASQ_FAST_CONV      = 128;
  localparam int ASQ_SLOW_TOTAL_MAX = 266;
  localparam int ASQ_FAST_TOTAL_MAX = 134;
  // body of a conversion after the start delay, in cycles
  localparam logic [8:0] ASQ_SLOW_BODY_CYC = 9'(ASQ_SLOW_CONV * ASQ_STATE_PER_CLK - 7);
  localparam logic [8:0] ASQ_FAST_BODY_CYC = 9'(ASQ_FAST_CONV * ASQ_STATE_PER_CLK - 3);
  localparam logic [8:0] ASQ_SLOW_DLY_CYC  = 9'(ASQ_SLOW_DELAY_MIN * ASQ_STATE_PER_CLK);
  localparam logic [8:0] ASQ_FAST_DLY_CYC  = 9'(ASQ_FAST_DELAY_MIN * ASQ_STATE_PER_CLK);
  localparam logic [2:0] ASQ_SLOW_DLY_SPAN = 3'(ASQ_SLOW_DELAY_MAX - ASQ_SLOW_DELAY_MIN);
  localparam logic [2:0] ASQ_FAST_DLY_SPAN = 3'(ASQ_FAST_DELAY_MAX - ASQ_FAST_DELAY_MIN);
  localparam logic [8:0] ASQ_SLOW_SMP_CYC  = 9'(ASQ_SLOW_SAMPLE * ASQ_STATE_PER_CLK);
  localparam logic [8:0] ASQ_FAST_SMP_CYC  = 9'(ASQ_FAST_SAMPLE * ASQ_STATE_PER_CLK);

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ASQ_IDLE,
    ASQ_DELAY,
    ASQ_CONV
  } asq_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } asq_bus_req_t;

  typedef struct packed {
    logic       done_flag;
    logic       irq_en;
    logic       go;
    logic       scan;
    logic       speed;
    logic [2:0] pick;
  } asq_ctrl_t;

endpackage : asq_pkg

/* File: asq_sequencer.sv */
// scan sequencer for a 10-bit successive-approximation converter, eight inputs in two groups
// assumes an analog core that returns a result whenever conv_end is seen, sync register port
// Contract
// - scan start converts input 0 for group 0, input 4 for group 1
// - next selected input starts right after previous conversion ends
// - scan keeps cycling until conversion go bit is cleared
// - each result goes to the result register of its input
// - setting go again restarts from first input of group
// - one write may change mode/pick and set go together
// - after full scan pass set done flag and restart at first input
// - done request raised when done flag set and irq enable set
// - start delay of 10..17 states slow, 6..9 states fast
// - conversion includes start delay plus 64 or 32 state sample window
// - single conversion totals 259..266 slow, 131..134 fast states
// - later scan conversions take exactly 256 slow or 128 fast states
// - with external start enable, a falling external pin sets go and starts
// - external start behaves like software go, except in single mode a pin edge in the last conversion cycle while an abort drains is dropped
// - external start detected on falling edge of the pin
// - irq enable gates the done request
// - done request offered as dma start source
// - dma access to any converter register clears done flag
// - done flag cleared by reading it as 1 then writing 0
// - results are 10-bit values
// - pins act analog from start, digital again when the sequencer returns to idle
// - pins of unused group stay usable as port pins
// - upper byte read latches lower byte; lower read returns held value
// - single mode clears go when the conversion completes
module asq_sequencer #(
  parameter int RES_W = 10
) (
  input  wire logic               mclk_i,
  input  wire logic               nrst_i,
  input  wire asq_pkg::asq_bus_req_t bus_i,
  input  wire logic               dma_access_i,
  output logic [7:0]              rdata_o,
  input  wire logic               external_start_pin_n_i,
  output logic [2:0]              conv_input_o,
  output logic                    sample_o,
  input  wire logic [RES_W-1:0]   conv_result_i,
  output logic [7:0]              analog_pin_en_o,
  output logic                    conversion_done_request_o,
  output logic                    dma_start_req_o
);
  import asq_pkg::*;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  asq_ctrl_t        ctrl_ff;
  logic             ext_en_ff;
  logic             pin_d_ff;
  logic             done_seen_ff;
  logic [RES_W-1:0] res_ff [4];
  logic [7:0]       hold_ff;
  logic [7:0]       rdata_ff;
  asq_state_t       state_ff;
  logic [8:0]       cnt_ff;
  logic [2:0]       ch_ff;
  logic [2:0]       phase_ff;
  logic             first_ff;
  logic             rep_ff;

  function automatic logic [2:0] first_input(input logic [2:0] pick, input logic scan);
    first_input = scan ? {pick[2], 2'b00} : pick;
  endfunction : first_input

  logic       ctrl_wr;
  logic       ext_fall;
  logic       start_go;
  logic       conv_end;
  logic       pass_end;
  logic [8:0] dly_cyc;
  logic [8:0] body_cyc;
  logic [8:0] smp_cyc;
  logic [8:0] conv_len;

  assign ctrl_wr  = bus_i.wr && (bus_i.addr == ASQ_OFS_CTRL_STAT);
  assign ext_fall = ext_en_ff && pin_d_ff && !external_start_pin_n_i;
  // go rising from idle, by software or pin, starts at the group's first input in scan mode, at the picked input in single mode
  assign start_go = (ctrl_wr && bus_i.wdata[ASQ_BIT_GO] && !ctrl_ff.go) || (ext_fall && !ctrl_ff.go);
  assign conv_end = (state_ff == ASQ_CONV) && (cnt_ff == 9'h000);
  assign pass_end = conv_end && (!ctrl_ff.scan || (ch_ff[1:0] == ctrl_ff.pick[1:0]));
  assign dly_cyc  = ctrl_ff.speed ? 9'(ASQ_FAST_DLY_CYC + 9'(phase_ff & {1'b0, ASQ_FAST_DLY_SPAN[1:0]}))
                                  : 9'(ASQ_SLOW_DLY_CYC + 9'(phase_ff & ASQ_SLOW_DLY_SPAN));
  assign body_cyc = ctrl_ff.speed ? ASQ_FAST_BODY_CYC : ASQ_SLOW_BODY_CYC;
  assign smp_cyc  = ctrl_ff.speed ? ASQ_FAST_SMP_CYC : ASQ_SLOW_SMP_CYC;
  assign conv_len = ctrl_ff.speed ? 9'(ASQ_FAST_CONV) : 9'(ASQ_SLOW_CONV);

  // ----------------------------------------------------------------
  // external pin edge
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      pin_d_ff <= 1'b1;
    end else begin
      pin_d_ff <= external_start_pin_n_i;
    end
  end

  // free phase counter makes the start delay vary with write timing
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      phase_ff <= 3'h0;
    end else begin
      phase_ff <= phase_ff + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // control / status
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      ctrl_ff      <= asq_ctrl_t'(ASQ_RST_CTRL_STAT);
      ext_en_ff    <= ASQ_RST_TRIG_CTRL[ASQ_BIT_TRGEN];
      done_seen_ff <= 1'b0;
    end else begin
      if (bus_i.wr && bus_i.addr == ASQ_OFS_TRIG_CTRL) begin
        ext_en_ff <= bus_i.wdata[ASQ_BIT_TRGEN];
      end
      if (bus_i.rd && bus_i.addr == ASQ_OFS_CTRL_STAT) begin
        done_seen_ff <= ctrl_ff.done_flag;
      end
      if (ctrl_wr) begin
        // a status read arms one clearing write only, so a stale read cannot clear a later flag
        done_seen_ff   <= 1'b0;
        ctrl_ff.irq_en <= bus_i.wdata[ASQ_BIT_IRQEN];
        ctrl_ff.scan   <= bus_i.wdata[ASQ_BIT_SCAN];
        ctrl_ff.speed  <= bus_i.wdata[ASQ_BIT_SPEED];
        ctrl_ff.pick   <= bus_i.wdata[ASQ_BIT_GROUP:0];
        ctrl_ff.go     <= bus_i.wdata[ASQ_BIT_GO];
        if (!bus_i.wdata[ASQ_BIT_DONE] && done_seen_ff) begin
          ctrl_ff.done_flag <= 1'b0;
        end
      end
      if (dma_access_i) begin
        ctrl_ff.done_flag <= 1'b0;
      end
      if (ext_fall) begin
        ctrl_ff.go <= 1'b1;
      end
      if (pass_end && !ctrl_ff.scan && !(ctrl_wr && bus_i.wdata[ASQ_BIT_GO] && !ctrl_ff.go)) begin
        ctrl_ff.go <= 1'b0;
      end
      // set wins over any clear in the same cycle
      if (pass_end) begin
        ctrl_ff.done_flag <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      state_ff <= ASQ_IDLE;
      cnt_ff   <= 9'h000;
      ch_ff    <= 3'h0;
      first_ff <= 1'b0;
      rep_ff   <= 1'b0;
    end else if (start_go) begin
      // a software start, or a pin start in scan mode, in the cycle an abort still drains is taken, else go would stick high while idle
      state_ff <= ASQ_DELAY;
      ch_ff    <= ctrl_wr ? first_input(bus_i.wdata[2:0], bus_i.wdata[ASQ_BIT_SCAN])
                          : first_input(ctrl_ff.pick, ctrl_ff.scan);
      cnt_ff   <= 9'h000;
      first_ff <= 1'b1;
      rep_ff   <= 1'b0;
    end else begin
      case (state_ff)
        ASQ_IDLE: begin
          state_ff <= ASQ_IDLE;
        end
        ASQ_DELAY: begin
          if (!ctrl_ff.go) begin
            state_ff <= ASQ_IDLE;
          end else if (first_ff) begin
            cnt_ff   <= dly_cyc - 9'h002;
            first_ff <= 1'b0;
          end else if (cnt_ff == 9'h000) begin
            state_ff <= ASQ_CONV;
            cnt_ff   <= body_cyc - 9'h001;
          end else begin
            cnt_ff <= cnt_ff - 9'h001;
          end
        end
        ASQ_CONV: begin
          if (!ctrl_ff.go) begin
            state_ff <= ASQ_IDLE;
          end else if (conv_end) begin
            if (!ctrl_ff.scan) begin
              state_ff <= ASQ_IDLE;
            end else begin
              // back to back, fixed length for every later conversion
              cnt_ff <= conv_len - 9'h001;
              rep_ff <= 1'b1;
              ch_ff  <= pass_end ? first_input(ctrl_ff.pick, 1'b1) : ch_ff + 3'h1;
            end
          end else begin
            cnt_ff <= cnt_ff - 9'h001;
          end
        end
        default: begin
          state_ff <= ASQ_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // result registers and read path
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < 4; i++) begin
        res_ff[i] <= '0;
      end
    end else if (conv_end) begin
      res_ff[ch_ff[1:0]] <= conv_result_i;
    end
  end

  logic [15:0] sel_word;
  assign sel_word = {res_ff[bus_i.addr[2:1]], {(16 - RES_W){1'b0}}};

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      hold_ff  <= 8'h00;
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= 8'h00;
      if (bus_i.rd) begin
        if (bus_i.addr <= ASQ_OFS_RES_D_LO) begin
          if (!bus_i.addr[0]) begin
            rdata_ff <= sel_word[15:8];
            hold_ff  <= sel_word[7:0];
          end else begin
            rdata_ff <= hold_ff;
          end
        end else if (bus_i.addr == ASQ_OFS_CTRL_STAT) begin
          rdata_ff <= ctrl_ff;
        end else if (bus_i.addr == ASQ_OFS_TRIG_CTRL) begin
          rdata_ff <= {ext_en_ff, ASQ_TRIG_RSVD[6:0]};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata_o                   = rdata_ff;
  assign conv_input_o              = ch_ff;
  // sample window is the first part of every conversion body, first or repeated
  assign sample_o                  = (state_ff == ASQ_CONV)
                                   && (cnt_ff >= (rep_ff ? conv_len : body_cyc) - smp_cyc);
  assign conversion_done_request_o = ctrl_ff.done_flag && ctrl_ff.irq_en;
  assign dma_start_req_o           = conversion_done_request_o;
  // only the active group goes analog; the other four stay port pins
  assign analog_pin_en_o           = (state_ff == ASQ_IDLE) ? 8'h00
                                   : (ctrl_ff.pick[2] ? 8'hF0 : 8'h0F);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_first_input;
    @(posedge mclk_i) disable iff (!nrst_i)
      (state_ff == ASQ_IDLE && start_go && ctrl_wr && bus_i.wdata[ASQ_BIT_SCAN])
      |=> ch_ff == {$past(bus_i.wdata[2]), 2'b00};
  endproperty
  a_first_input: assert property (p_first_input) else $error("scan did not start at group first input");

  property p_done_on_pass;
    @(posedge mclk_i) disable iff (!nrst_i) pass_end |=> ctrl_ff.done_flag;
  endproperty
  a_done_on_pass: assert property (p_done_on_pass) else $error("done flag not set after pass");

  property p_single_clear_go;
    @(posedge mclk_i) disable iff (!nrst_i)
      (pass_end && !ctrl_ff.scan && !ctrl_wr && !ext_fall) |=> !ctrl_ff.go;
  endproperty
  a_single_clear_go: assert property (p_single_clear_go) else $error("go not cleared in single mode");

  property p_req_gate;
    @(posedge mclk_i) disable iff (!nrst_i)
      (pass_end && ctrl_ff.irq_en && !ctrl_wr) |=> conversion_done_request_o;
  endproperty
  a_req_gate: assert property (p_req_gate) else $error("done request not gated by enable");

  property p_dma_clear;
    @(posedge mclk_i) disable iff (!nrst_i) (dma_access_i && !pass_end) |=> !ctrl_ff.done_flag;
  endproperty
  a_dma_clear: assert property (p_dma_clear) else $error("dma access did not clear done");

  property p_ext_start;
    @(posedge mclk_i) disable iff (!nrst_i) (ext_fall && !pass_end) |=> ctrl_ff.go;
  endproperty
  a_ext_start: assert property (p_ext_start) else $error("external edge did not set go");

  property p_scan_next;
    @(posedge mclk_i) disable iff (!nrst_i)
      (conv_end && ctrl_ff.scan && ctrl_ff.go && !pass_end) |=> state_ff == ASQ_CONV && ch_ff == $past(ch_ff) + 3'h1;
  endproperty
  a_scan_next: assert property (p_scan_next) else $error("next input not started at once");

  property p_pins_other_group;
    @(posedge mclk_i) disable iff (!nrst_i)
      (state_ff != ASQ_IDLE) |-> (analog_pin_en_o & (ctrl_ff.pick[2] ? 8'h0F : 8'hF0)) == 8'h00;
  endproperty
  a_pins_other_group: assert property (p_pins_other_group) else $error("unused group pins taken");

  property p_idle_digital;
    @(posedge mclk_i) disable iff (!nrst_i) (state_ff == ASQ_IDLE) |-> analog_pin_en_o == 8'h00;
  endproperty
  a_idle_digital: assert property (p_idle_digital) else $error("pins analog while idle");

  c_scan_pass: cover property (@(posedge mclk_i) disable iff (!nrst_i) pass_end && ctrl_ff.scan);
  c_single_done: cover property (@(posedge mclk_i) disable iff (!nrst_i) pass_end && !ctrl_ff.scan);
  c_ext_start: cover property (@(posedge mclk_i) disable iff (!nrst_i) ext_fall && state_ff == ASQ_IDLE);
  c_dma_clear: cover property (@(posedge mclk_i) disable iff (!nrst_i) dma_access_i && ctrl_ff.done_flag);
  c_req_raised: cover property (@(posedge mclk_i) disable iff (!nrst_i) $rose(conversion_done_request_o));

  property p_no_clear_unseen;
    @(posedge mclk_i) disable iff (!nrst_i)
      (ctrl_wr && !done_seen_ff && !dma_access_i && ctrl_ff.done_flag) |=> ctrl_ff.done_flag;
  endproperty
  a_no_clear_unseen: assert property (p_no_clear_unseen) else $error("done cleared without a status read");

  property p_level_no_start;
    @(posedge mclk_i) disable iff (!nrst_i)
      (ext_en_ff && !pin_d_ff && !external_start_pin_n_i && !ctrl_wr && state_ff == ASQ_IDLE && !ctrl_ff.go)
      |=> state_ff == ASQ_IDLE;
  endproperty
  a_level_no_start: assert property (p_level_no_start) else $error("held low pin started a conversion");

  property p_restart_first;
    @(posedge mclk_i) disable iff (!nrst_i)
      (start_go && !ctrl_wr) |=> ch_ff == first_input($past(ctrl_ff.pick), $past(ctrl_ff.scan));
  endproperty
  a_restart_first: assert property (p_restart_first) else $error("pin start not at first input");

endmodule : asq_sequencer

/* File: asq_core_model.sv */
// behavioural model of the analog core behind the sequencer
// assumes the sequencer samples conv_result_i in the last cycle of each conversion
module asq_core_model (
  input  wire logic [2:0] conv_input_i,
  input  wire logic       sample_i,
  output logic [9:0]      conv_result_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // result per input
  // ----------------------------------------------------------------
  // each input gives its own 10-bit code so a wrong register mapping shows up
  assign conv_result_o = {conv_input_i, 7'h5A};
endmodule : asq_core_model

/* File: test_adc_scan_sequencer.sv */
// self-checking bench for the scan sequencer: register port, pin trigger, dma strobe
// assumes one 25 MHz clock and the analog core model on the result side
module test_adc_scan_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  import asq_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic          mclk_i;
  logic          nrst_i;
  asq_bus_req_t  bus;
  logic          dma_access;
  logic [7:0]    rdata;
  logic          ext_start_n;
  logic [2:0]    conv_input;
  logic          sample;
  logic [9:0]    conv_result;
  logic [7:0]    pin_en;
  logic          done_req;
  logic          dma_req;
  int            bad_count;
  int            n_compared;
  asq_sequencer dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .bus_i(bus), .dma_access_i(dma_access),
    .rdata_o(rdata), .external_start_pin_n_i(ext_start_n), .conv_input_o(conv_input),
    .sample_o(sample), .conv_result_i(conv_result), .analog_pin_en_o(pin_en),
    .conversion_done_request_o(done_req), .dma_start_req_o(dma_req));
  asq_core_model core (.conv_input_i(conv_input), .sample_i(sample), .conv_result_o(conv_result));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8
  task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
    n_compared++;
    if (g < lo || g > hi) begin
      bad_count++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : chk_rng
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    bus.wr    <= 1'b1;
    bus.addr  <= a;
    bus.wdata <= d;
    @(posedge mclk_i);
    bus.wr    <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    bus.rd   <= 1'b1;
    bus.addr <= a;
    @(posedge mclk_i);
    bus.rd   <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  // cycles until a flag goes high, bounded
  task automatic wait_req(output int n, output int s);
    n = 0;
    s = 0;
    while (done_req !== 1'b1 && n < 400) begin
      @(posedge mclk_i);
      #1 n++;
      if (sample === 1'b1) begin
        s++;
      end
    end
  endtask : wait_req
  task automatic wait_input(input logic [2:0] ch, output int n);
    n = 0;
    while (conv_input !== ch && n < 400) begin
      @(posedge mclk_i);
      #1 n++;
    end
  endtask : wait_input
  function automatic logic [9:0] res_of(input logic [2:0] ch);
    return {ch, 7'h5A};
  endfunction : res_of
  task automatic chk_result(input logic [7:0] hi_ofs, input logic [2:0] ch);
    logic [7:0] d;
    logic [9:0] r;
    r = res_of(ch);
    rd_reg(hi_ofs, d);
    chk8("result hi", r[9:2], d);
    rd_reg(hi_ofs + 8'h01, d);
    chk8("result lo", {r[1:0], 6'h00}, d);
  endtask : chk_result
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values;
    logic [7:0] d;
    rd_reg(ASQ_OFS_CTRL_STAT, d);
    chk8("ctrl reset", 8'h00, d);
    rd_reg(ASQ_OFS_TRIG_CTRL, d);
    chk8("trig reset", 8'h7F, d);
    wr_reg(8'h0A, 8'hFF);
    rd_reg(8'h0A, d);
    chk8("unmapped", 8'h00, d);
  endtask : t_reset_values
  // single slow conversion of input 1 with the done request enabled
  task automatic t_single_slow;
    logic [7:0] d;
    int n;
    int s;
    wr_reg(ASQ_OFS_CTRL_STAT, 8'h61);
    #1 chk8("pins busy g0", 8'h0F, pin_en);
    wait_req(n, s);
    chk_rng("single slow time", 259, 266, n);
    chk_rng("slow sample window", 64, 64, s);
    chk8("pins idle", 8'h00, pin_en);
    rd_reg(ASQ_OFS_CTRL_STAT, d);
    chk8("status done", 8'hC1, d);
    chk_result(ASQ_OFS_RES_B_HI, 3'h1);
    wr_reg(ASQ_OFS_CTRL_STAT, 8'h41);
    #1 chk8("req cleared", 8'h00, {7'h00, done_req});
  endtask : t_single_slow
  // fast scan of inputs 4..6 with the request masked, stopped, then dma clear
  task automatic t_scan_fast;
    logic [7:0] d;
    int n;
    int s;
    wr_reg(ASQ_OFS_CTRL_STAT, 8'h3E);
    #1 chk8("pins busy g1", 8'hF0, pin_en);
    chk8("first input", 8'h04, {5'h00, conv_input});
    wait_input(3'h5, n);
    chk_rng("first scan conv", 131, 134, n);
    wait_input(3'h6, n);
    chk_rng("next input gap", 128, 128, n);
    wait_input(3'h4, n);
    chk_rng("wrap gap", 128, 128, n);
    chk8("masked req", 8'h00, {6'h00, done_req, dma_req});
    rd_reg(ASQ_OFS_CTRL_STAT, d);
    chk8("scan status", 8'hBE, d);
    chk_result(ASQ_OFS_RES_C_HI, 3'h6);
    // stop with done written as 1 so the flag survives for the dma clear
    wr_reg(ASQ_OFS_CTRL_STAT, 8'hDE);
    @(posedge mclk_i);
    #1 chk8("stop pins", 8'h00, pin_en);
    chk8("req before dma", 8'h03, {6'h00, done_req, dma_req});
    @(posedge mclk_i);
    dma_access <= 1'b1;
    @(posedge mclk_i);
    dma_access <= 1'b0;
    #1 chk8("dma clear", 8'h00, {6'h00, done_req, dma_req});
    wr_reg(ASQ_OFS_CTRL_STAT, 8'h70);
    #1 chk8("restart input", 8'h00, {5'h00, conv_input});
    wait_req(n, s);
    chk_rng("scan slow first", 259, 266, n);
    chk8("dma request", 8'h03, {6'h00, done_req, dma_req});
    wr_reg(ASQ_OFS_CTRL_STAT, 8'h40);
    #1 chk8("no clear unread", 8'h03, {6'h00, done_req, dma_req});
    rd_reg(ASQ_OFS_CTRL_STAT, d);
    chk8("status seen", 8'hC0, d);
    wr_reg(ASQ_OFS_CTRL_STAT, 8'h40);
    #1 chk8("read then clear", 8'h00, {6'h00, done_req, dma_req});
  endtask : t_scan_fast
  // pin trigger: falling edge starts one conversion, a held low level does not
  task automatic t_ext_start;
    logic [7:0] d;
    int n;
    int s;
    wr_reg(ASQ_OFS_TRIG_CTRL, 8'hFF);
    rd_reg(ASQ_OFS_TRIG_CTRL, d);
    chk8("trig enable", 8'hFF, d);
    // input 3 has not been converted before, so its result proves this conversion
    wr_reg(ASQ_OFS_CTRL_STAT, 8'h4B);
    @(posedge mclk_i);
    ext_start_n <= 1'b0;
    @(posedge mclk_i);
    #1 chk8("ext pins", 8'h0F, pin_en);
    wait_req(n, s);
    chk_rng("ext fast time", 131, 134, n);
    chk_rng("fast sample window", 32, 32, s);
    chk_result(ASQ_OFS_RES_D_HI, 3'h3);
    repeat (20) @(posedge mclk_i);
    #1 chk8("level no restart", 8'h00, pin_en);
    ext_start_n <= 1'b1;
  endtask : t_ext_start
  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end
  initial begin
    // a full run needs about 1100 cycles; this span leaves wide margin
    #400000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    bad_count   = 0;
    n_compared  = 0;
    nrst_i      = 1'b0;
    bus         = '0;
    dma_access  = 1'b0;
    ext_start_n = 1'b1;
    repeat (2) @(posedge mclk_i);
    nrst_i <= 1'b1;
    t_reset_values();
    t_single_slow();
    t_scan_fast();
    t_ext_start();
    report_and_stop();
  end
endmodule : test_adc_scan_sequencer
